// ===== timer_flag_pkg.sv
package timer_flag_pkg;
    // Byte offsets of the register bank
    localparam logic [11:0] ENABLES_OFS = 12'h314;
    localparam logic [11:0] FLAGS_OFS = 12'h318;
    localparam logic [11:0] CLEAR_OFS = 12'h31C;
    // Reset and fixed read values
    localparam logic [31:0] FLAGS_RST = 32'h0000_0000;
    localparam logic [31:0] CLEAR_READ = 32'h0000_03FF;
    localparam logic [10:0] ENABLES_RST = 11'h000;
    localparam logic FLAG_RST = 1'b0;
    localparam logic [31:0] DATA_RST = 32'h0000_0000;
    // Implemented event bits: 0..6 and 9
    localparam logic [10:0] EVENT_MASK = 11'h27F;
    // Field positions
    localparam int WRAP_BIT = 0;
    localparam int TRIG_BIT = 1;
    localparam int UNDER_BIT = 2;
    localparam int CHAN_LSB = 3;
    localparam int CHAN_CNT = 4;
    localparam int FLIP_BIT = 9;
    localparam int SENSE_BIT = 10;
    localparam int FLAG_W = 11;
    localparam int EVT_CNT = 8;

    typedef enum logic [1:0] {
        SEL_NONE,
        SEL_ENABLES,
        SEL_FLAGS,
        SEL_CLEAR
    } reg_sel_t;

    // Flag word in register bit order
    typedef struct packed {
        logic sense;
        logic sense_flip;
        logic [1:0] rsvd;
        logic [3:0] chan;
        logic under;
        logic trig;
        logic wrap;
    } flags_t;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [11:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } wb_req_t;
endpackage

// ===== sticky_flag.sv
`timescale 1ns/1ps
module sticky_flag (
    input wire logic clk_i, // Clock
    input wire logic rst_i, // Sync reset, high
    input wire logic set_i, // Hardware event
    input wire logic clr_i, // Software clear
    output logic nxt_o, // Value after this edge
    output logic q_o // Held flag
);
    logic q_r;
    logic q_nxt;

    // Set is applied last so it wins over a clear in the same cycle
    always_comb begin
        q_nxt = q_r;
        if (clr_i) begin
            q_nxt = 1'b0;
        end
        if (set_i) begin
            q_nxt = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q_r <= timer_flag_pkg::FLAG_RST;
        end else begin
            q_r <= q_nxt;
        end
    end

    assign nxt_o = q_nxt;
    assign q_o = q_r;
endmodule

// ===== wb_port.sv
`timescale 1ns/1ps
module wb_port (
    input wire logic clk_i, // Clock
    input wire logic rst_i, // Sync reset, high
    input timer_flag_pkg::wb_req_t req_i, // Bus request
    input wire logic [31:0] rdata_i, // Read value for req_i.adr
    output logic wr_o, // Write takes effect this edge
    output logic ack_o, // Registered acknowledge
    output logic [31:0] dat_o // Registered read data
);
    logic ack_r;
    logic ack_nxt;
    logic [31:0] dat_r;
    logic [31:0] dat_nxt;
    logic start;

    assign start = req_i.cyc && req_i.stb && !ack_r;

    always_comb begin
        ack_nxt = start;
        dat_nxt = dat_r;
        if (start && !req_i.we) begin
            dat_nxt = rdata_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
            dat_r <= timer_flag_pkg::DATA_RST;
        end else begin
            ack_r <= ack_nxt;
            dat_r <= dat_nxt;
        end
    end

    // Writes land on the edge where the master sees ack
    assign wr_o = req_i.cyc && req_i.stb && req_i.we && ack_r;
    assign ack_o = ack_r;
    assign dat_o = dat_r;
endmodule

// ===== timer_event_flag_bank.sv
// Decided for this implementation: register access over Wishbone.
`timescale 1ns/1ps
// What this block does
// (RULE_01) Status bit 10 shows encoder counting sense: 0 forward, 1 reverse.
// (RULE_02) Status bit 9 sets when counting sense changes, else reads 0.
// (RULE_03) Bits 3 to 6 flag channel 1 to 4 compare or capture events.
// (RULE_04) Bit 2 sets on counter underflow, only in encoder counting mode.
// (RULE_05) Bit 1 sets on a trigger event, else reads 0.
// (RULE_06) Bit 0 sets when the counter passes from reload value to zero.
// (RULE_07) Flag register at 0x318 resets to zero; bits 31:11, 8:7 reserved.
// (RULE_08) Writing 0 to clear bits 3 to 6 clears channel flags; 1 does nothing.
// (RULE_09) Writing 0 to clear bit 9 clears sense-change flag; 1 does nothing.
// (RULE_10) Writing 0 to clear bit 2 clears underflow, only in encoder mode.
// (RULE_11) Writing 0 to clear bits 0 and 1 clears wrap and trigger flags.
// (RULE_12) Clear register at 0x31C resets to 0x3FF and always reads 0x3FF.
// (RULE_13) Enable register holds one enable per flag in the same positions.
// (RULE_14) Flags stay set until cleared; a simultaneous set beats the clear.
// (RULE_15) Interrupt is the OR of every flag ANDed with its enable.
module timer_event_flag_bank (
    input wire logic clk_i, // Clock, 10 MHz
    input wire logic rst_i, // Sync reset, high
    input wire logic cyc_i, // Wishbone cycle
    input wire logic stb_i, // Wishbone strobe
    input wire logic we_i, // Wishbone write enable
    input wire logic [11:0] adr_i, // Wishbone byte address
    input wire logic [3:0] sel_i, // Wishbone byte selects
    input wire logic [31:0] dat_i, // Wishbone write data
    output logic [31:0] dat_o, // Wishbone read data
    output logic ack_o, // Wishbone acknowledge
    input wire logic [15:0] count_i, // Timer count value
    input wire logic [15:0] reload_value_i, // Timer reload value
    input wire logic sense_i, // Encoder sense, 1 reverse
    input wire logic enc_mode_i, // Encoder counting mode active
    input wire logic [3:0] chan_evt_i, // Channel 1..4 event pulses
    input wire logic underflow_evt_i, // Counter underflow pulse
    input wire logic trigger_evt_i, // Trigger event pulse
    output logic irq_o // Timer interrupt, level
);
    timer_flag_pkg::wb_req_t req;
    timer_flag_pkg::reg_sel_t rd_sel;
    timer_flag_pkg::reg_sel_t wr_sel;
    timer_flag_pkg::flags_t flags;
    logic [31:0] rdata;
    logic [31:0] lane;
    logic wr;
    logic wr_clear;
    logic wr_en;

    // Address decode shared by read and write paths
    function automatic timer_flag_pkg::reg_sel_t decode(input logic [11:0] adr);
        timer_flag_pkg::reg_sel_t s;
        s = timer_flag_pkg::SEL_NONE;
        if (adr[11:2] == timer_flag_pkg::ENABLES_OFS[11:2]) begin
            s = timer_flag_pkg::SEL_ENABLES;
        end else if (adr[11:2] == timer_flag_pkg::FLAGS_OFS[11:2]) begin
            s = timer_flag_pkg::SEL_FLAGS;
        end else if (adr[11:2] == timer_flag_pkg::CLEAR_OFS[11:2]) begin
            s = timer_flag_pkg::SEL_CLEAR;
        end
        return s;
    endfunction

    // Byte selects widened to a bit mask
    function automatic logic [31:0] lane_mask(input logic [3:0] sel);
        logic [31:0] m;
        m = 32'h0000_0000;
        for (int b = 0; b < 4; b++) begin
            m[b*8 +: 8] = {8{sel[b]}};
        end
        return m;
    endfunction

    assign req = '{cyc: cyc_i, stb: stb_i, we: we_i, adr: adr_i,
                   sel: sel_i, dat: dat_i};
    assign rd_sel = decode(req.adr);
    assign wr_sel = decode(req.adr);
    assign lane = lane_mask(req.sel);
    assign wr_clear = wr && (wr_sel == timer_flag_pkg::SEL_CLEAR);
    assign wr_en = wr && (wr_sel == timer_flag_pkg::SEL_ENABLES);

    wb_port u_port (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .req_i(req),
        .rdata_i(rdata),
        .wr_o(wr),
        .ack_o(ack_o),
        .dat_o(dat_o)
    );

    // History of the counter and sense inputs
    logic [15:0] cnt_prev_r;
    logic [15:0] cnt_prev_nxt;
    logic [15:0] rel_prev_r;
    logic [15:0] rel_prev_nxt;
    logic sense_r;
    logic sense_nxt;
    logic primed_r;
    logic primed_nxt;

    always_comb begin
        cnt_prev_nxt = count_i;
        rel_prev_nxt = reload_value_i;
        sense_nxt = sense_i; // RULE_01
        primed_nxt = 1'b1;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_prev_r <= 16'h0000;
            rel_prev_r <= 16'h0000;
            sense_r <= 1'b0;
            primed_r <= 1'b0;
        end else begin
            cnt_prev_r <= cnt_prev_nxt;
            rel_prev_r <= rel_prev_nxt;
            sense_r <= sense_nxt;
            primed_r <= primed_nxt;
        end
    end

    // Event sources, in sticky-cell order: wrap, trig, under, chan1..4, flip
    logic wrap_evt;
    logic flip_evt;
    logic under_evt;
    logic [7:0] evt_set;
    logic [7:0] evt_clr;
    logic [7:0] evt_q;
    logic [7:0] evt_nxt;
    logic [31:0] zero_wr;

    // Reload at zero would wrap every tick, so a zero previous count is ignored
    assign wrap_evt = primed_r && (cnt_prev_r == rel_prev_r)
                      && (cnt_prev_r != 16'h0000) && (count_i == 16'h0000); // RULE_06
    // First cycle after reset has no valid history to compare against
    assign flip_evt = primed_r && (sense_i != sense_r); // RULE_02
    assign under_evt = underflow_evt_i && enc_mode_i; // RULE_04
    assign evt_set = {flip_evt, chan_evt_i, under_evt, trigger_evt_i, wrap_evt}; // RULE_03 RULE_05

    // A zero written in a selected lane clears; ones and unselected lanes do not
    assign zero_wr = lane & ~req.dat;
    always_comb begin
        evt_clr = 8'h00;
        if (wr_clear) begin
            evt_clr[0] = zero_wr[timer_flag_pkg::WRAP_BIT]; // RULE_11
            evt_clr[1] = zero_wr[timer_flag_pkg::TRIG_BIT]; // RULE_11
            evt_clr[2] = zero_wr[timer_flag_pkg::UNDER_BIT] && enc_mode_i; // RULE_10
            evt_clr[6:3] = zero_wr[timer_flag_pkg::CHAN_LSB +: 4]; // RULE_08
            evt_clr[7] = zero_wr[timer_flag_pkg::FLIP_BIT]; // RULE_09
        end
    end

    genvar g;
    generate
        for (g = 0; g < timer_flag_pkg::EVT_CNT; g++) begin : g_flag
            sticky_flag u_flag (
                .clk_i(clk_i),
                .rst_i(rst_i),
                .set_i(evt_set[g]),
                .clr_i(evt_clr[g]),
                .nxt_o(evt_nxt[g]),
                .q_o(evt_q[g]) // RULE_14
            );
        end
    endgenerate

    // Reserved bits 8:7 tie to zero
    assign flags = '{sense: sense_r, sense_flip: evt_q[7], rsvd: 2'b00,
                     chan: evt_q[6:3], under: evt_q[2], trig: evt_q[1],
                     wrap: evt_q[0]}; // RULE_07

    // Enable register and interrupt output
    logic [10:0] en_r;
    logic [10:0] en_nxt;
    logic irq_r;
    logic irq_nxt;
    logic [10:0] flags_nxt;

    always_comb begin
        en_nxt = en_r;
        if (wr_en) begin
            en_nxt = ((en_r & ~lane[10:0]) | (req.dat[10:0] & lane[10:0]))
                     & timer_flag_pkg::EVENT_MASK; // RULE_13
        end
    end

    // Interrupt computed from next values so the pin tracks the flags exactly
    always_comb begin
        flags_nxt = {1'b0, evt_nxt[7], 2'b00, evt_nxt[6:0]};
        irq_nxt = |(flags_nxt & en_nxt); // RULE_15
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            en_r <= timer_flag_pkg::ENABLES_RST;
            irq_r <= 1'b0;
        end else begin
            en_r <= en_nxt;
            irq_r <= irq_nxt;
        end
    end

    assign irq_o = irq_r;

    // Read mux; unmapped words read as zero
    always_comb begin
        case (rd_sel)
            timer_flag_pkg::SEL_ENABLES: rdata = {21'h000000, en_r};
            timer_flag_pkg::SEL_FLAGS: rdata = {21'h000000, flags}; // RULE_07
            timer_flag_pkg::SEL_CLEAR: rdata = timer_flag_pkg::CLEAR_READ; // RULE_12
            default: rdata = 32'h0000_0000;
        endcase
    end

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    sequence at_reload_s;
        primed_r && (count_i == reload_value_i) && (count_i != 16'h0000);
    endsequence

    sequence to_zero_s;
        count_i == 16'h0000;
    endsequence

    sequence clear_write_s(int bitpos);
        wr_clear && lane[bitpos] && !req.dat[bitpos];
    endsequence

    sense_track_a: assert property ( // RULE_01
        primed_r |-> flags.sense == $past(sense_i))
        else $error("sense bit does not follow encoder sense");

    flip_set_a: assert property ( // RULE_02
        (primed_r && sense_i != sense_r) |=> flags.sense_flip)
        else $error("sense change not flagged");

    flip_idle_a: assert property ( // RULE_02
        (!flags.sense_flip && primed_r && sense_i == sense_r) |=> !flags.sense_flip)
        else $error("sense flag set without a change");

    chan_set_a: assert property ( // RULE_03
        (chan_evt_i != 4'h0) |=> ((flags.chan & $past(chan_evt_i)) == $past(chan_evt_i)))
        else $error("channel event not flagged");

    under_mode_a: assert property ( // RULE_04
        (underflow_evt_i && !enc_mode_i && !flags.under) |=> !flags.under)
        else $error("underflow flagged outside encoder mode");

    under_set_a: assert property ( // RULE_04
        (underflow_evt_i && enc_mode_i) |=> flags.under)
        else $error("encoder underflow not flagged");

    trig_set_a: assert property ( // RULE_05
        trigger_evt_i |=> flags.trig)
        else $error("trigger not flagged");

    wrap_set_a: assert property ( // RULE_06
        at_reload_s ##1 to_zero_s |=> flags.wrap)
        else $error("reload to zero pass not flagged");

    reset_zero_a: assert property ( // RULE_07
        disable iff (1'b0) rst_i |=> (flags == timer_flag_pkg::FLAGS_RST[10:0]) && !irq_o)
        else $error("flags not zero after reset");

    reserved_zero_a: assert property ( // RULE_07
        (cyc_i && stb_i && !we_i && !ack_o && rd_sel == timer_flag_pkg::SEL_FLAGS)
        |=> (dat_o[31:11] == 21'h000000) && (dat_o[8:7] == 2'b00))
        else $error("reserved flag bits not zero");

    chan_clear_a: assert property ( // RULE_08
        (clear_write_s(3) and !chan_evt_i[0]) |=> !flags.chan[0])
        else $error("channel 1 flag not cleared by zero");

    clear_one_a: assert property ( // RULE_08
        (wr_clear && lane[3] && req.dat[3] && flags.chan[0]) |=> flags.chan[0])
        else $error("writing one cleared a channel flag");

    flip_clear_a: assert property ( // RULE_09
        (clear_write_s(9) and primed_r && sense_i == sense_r) |=> !flags.sense_flip)
        else $error("sense change flag not cleared");

    under_keep_a: assert property ( // RULE_10
        (clear_write_s(2) and flags.under && !enc_mode_i) |=> flags.under)
        else $error("underflow cleared outside encoder mode");

    wrap_clear_a: assert property ( // RULE_11
        (clear_write_s(0) and !wrap_evt) |=> !flags.wrap)
        else $error("wrap flag not cleared");

    trig_clear_a: assert property ( // RULE_11
        (clear_write_s(1) and !trigger_evt_i) |=> !flags.trig)
        else $error("trigger flag not cleared");

    clear_read_a: assert property ( // RULE_12
        (cyc_i && stb_i && !we_i && !ack_o && adr_i == timer_flag_pkg::CLEAR_OFS)
        ##1 ack_o |-> dat_o == timer_flag_pkg::CLEAR_READ)
        else $error("clear register read is not 0x3FF");

    set_wins_a: assert property ( // RULE_14
        (clear_write_s(1) and trigger_evt_i) |=> flags.trig)
        else $error("clear beat a simultaneous trigger");

    sticky_hold_a: assert property ( // RULE_14
        (flags.trig && !wr_clear) |=> flags.trig)
        else $error("trigger flag dropped without a clear");

    irq_gate_a: assert property ( // RULE_15
        irq_o == |({1'b0, flags.sense_flip, flags.rsvd, flags.chan, flags.under,
                    flags.trig, flags.wrap} & en_r)) // RULE_13
        else $error("interrupt does not match enabled flags");

    ack_pulse_a: assert property (
        ack_o |=> !ack_o)
        else $error("ack held longer than one cycle");

    ack_answer_a: assert property (
        (cyc_i && stb_i && !ack_o) |=> ack_o)
        else $error("request not answered in one cycle");

    unmapped_zero_a: assert property (
        (cyc_i && stb_i && !we_i && !ack_o && rd_sel == timer_flag_pkg::SEL_NONE)
        |=> dat_o == 32'h0000_0000)
        else $error("unmapped read not zero");

    chan4_clear_a: assert property ( // RULE_08
        (clear_write_s(6) and !chan_evt_i[3]) |=> !flags.chan[3])
        else $error("channel 4 flag not cleared by zero");

    clear_lane_a: assert property ( // RULE_08
        (wr_clear && !lane[3] && flags.chan[0]) |=> flags.chan[0])
        else $error("unselected lane cleared a channel flag");

    under_clear_a: assert property ( // RULE_10
        (clear_write_s(2) and enc_mode_i && !underflow_evt_i) |=> !flags.under)
        else $error("underflow flag not cleared in encoder mode");

    wrap_hold_a: assert property ( // RULE_14
        (flags.wrap && !wr_clear) |=> flags.wrap)
        else $error("wrap flag dropped without a clear");

    chan_hold_a: assert property ( // RULE_14
        (flags.chan[3] && !wr_clear) |=> flags.chan[3])
        else $error("channel 4 flag dropped without a clear");

    en_write_a: assert property ( // RULE_13
        (wr_en && lane[0] && req.dat[1]) |=> en_r[1])
        else $error("enable write did not land");
endmodule

// ===== tb_timer_event_flag_bank.sv
`timescale 1ns/1ps
module tb_timer_event_flag_bank;
    logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, irq_o;
    logic [11:0] adr_i;
    logic [3:0] sel_i, chan_evt_i;
    logic [31:0] dat_i, dat_o, rd, exp_flags;
    logic [15:0] count_i, reload_value_i;
    logic sense_i, enc_mode_i, underflow_evt_i, trigger_evt_i;
    int err_count = 0;
    int check_count = 0;
    int cycles = 0;
    localparam logic [11:0] FLG = timer_flag_pkg::FLAGS_OFS;
    localparam logic [11:0] CLR = timer_flag_pkg::CLEAR_OFS;
    localparam logic [11:0] ENA = timer_flag_pkg::ENABLES_OFS;

    timer_event_flag_bank DUT (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .count_i(count_i), .reload_value_i(reload_value_i), .sense_i(sense_i),
        .enc_mode_i(enc_mode_i), .chan_evt_i(chan_evt_i),
        .underflow_evt_i(underflow_evt_i), .trigger_evt_i(trigger_evt_i), .irq_o(irq_o)
    );

    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] expv);
        check_count++;
        if (seen !== expv) begin
            err_count++;
            $display("[FAIL] t=%0t seen=%08h exp=%08h", $time, seen, expv);
        end
    endtask

    task automatic give_verdict();
        $display("checks=%0d mismatches=%0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Classic single cycle; answer taken only at the edge that samples ack high
    task automatic wb_cycle(input logic w, input logic [11:0] a, input logic [3:0] s,
                            input logic [31:0] d, output logic [31:0] q);
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        sel_i <= s;
        dat_i <= d;
        do @(posedge clk_i); while (ack_o !== 1'b1);
        q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb_cycle(1'b1, a, 4'hF, d, q);
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] expv);
        wb_cycle(1'b0, a, 4'hF, 32'h0000_0000, rd);
        check(rd, expv);
    endtask

    // One-cycle event pulses, bits laid out as in the flag word
    task automatic fire(input logic [10:0] b);
        @(posedge clk_i);
        chan_evt_i <= b[6:3];
        underflow_evt_i <= b[2];
        trigger_evt_i <= b[1];
        @(posedge clk_i);
        chan_evt_i <= 4'h0;
        underflow_evt_i <= 1'b0;
        trigger_evt_i <= 1'b0;
    endtask

    // Two edges so an enable write has surely reached the interrupt register
    task automatic irq_chk(input logic e);
        repeat (2) @(posedge clk_i);
        check({31'h0000_0000, irq_o}, {31'h0000_0000, e});
    endtask

    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            err_count++;
            give_verdict();
        end
    end

    initial begin
        rst_i = 1'b1;
        cyc_i = 1'b0;
        stb_i = 1'b0;
        we_i = 1'b0;
        adr_i = 12'h000;
        sel_i = 4'h0;
        dat_i = 32'h0000_0000;
        count_i = 16'h0000;
        reload_value_i = 16'h0010;
        sense_i = 1'b0;
        enc_mode_i = 1'b1;
        chan_evt_i = 4'h0;
        underflow_evt_i = 1'b0;
        trigger_evt_i = 1'b0;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;

        rd_chk(FLG, 32'h0000_0000);
        rd_chk(CLR, 32'h0000_03FF);
        rd_chk(ENA, 32'h0000_0000);
        rd_chk(12'h300, 32'h0000_0000);
        wr(12'h300, 32'hFFFF_FFFF);
        rd_chk(12'h300, 32'h0000_0000);
        wr(FLG, 32'hFFFF_FFFF);
        rd_chk(FLG, 32'h0000_0000);
        $display("test reset_map done");

        wb_cycle(1'b1, ENA, 4'h1, 32'hFFFF_FFFF, rd);
        rd_chk(ENA, 32'h0000_007F);
        wr(ENA, 32'hFFFF_FFFF);
        rd_chk(ENA, 32'h0000_027F);
        wr(ENA, 32'h0000_0000);
        $display("test enables done");

        fire(11'h07E);
        exp_flags = 32'h0000_007E;
        rd_chk(FLG, exp_flags);
        wr(CLR, 32'hFFFF_FFFF);
        rd_chk(FLG, exp_flags);
        rd_chk(CLR, 32'h0000_03FF);
        wb_cycle(1'b1, CLR, 4'h2, 32'h0000_0000, rd);
        rd_chk(FLG, exp_flags);
        for (int b = 1; b <= 6; b++) begin
            wr(CLR, 32'hFFFF_FFFF ^ (32'h0000_0001 << b));
            exp_flags = exp_flags & ~(32'h0000_0001 << b);
            rd_chk(FLG, exp_flags);
        end
        $display("test events_clear done");

        @(posedge clk_i);
        count_i <= 16'h0010;
        @(posedge clk_i);
        count_i <= 16'h0000;
        rd_chk(FLG, 32'h0000_0001);
        wr(CLR, 32'hFFFF_FFFE);
        rd_chk(FLG, 32'h0000_0000);
        $display("test wrap done");

        sense_i <= 1'b1;
        rd_chk(FLG, 32'h0000_0600);
        wr(CLR, 32'hFFFF_FDFF);
        rd_chk(FLG, 32'h0000_0400);
        sense_i <= 1'b0;
        rd_chk(FLG, 32'h0000_0200);
        wr(CLR, 32'hFFFF_FDFF);
        rd_chk(FLG, 32'h0000_0000);
        $display("test sense done");

        enc_mode_i <= 1'b0;
        fire(11'h004);
        rd_chk(FLG, 32'h0000_0000);
        enc_mode_i <= 1'b1;
        fire(11'h004);
        rd_chk(FLG, 32'h0000_0004);
        enc_mode_i <= 1'b0;
        wr(CLR, 32'hFFFF_FFFB);
        rd_chk(FLG, 32'h0000_0004);
        enc_mode_i <= 1'b1;
        wr(CLR, 32'hFFFF_FFFB);
        rd_chk(FLG, 32'h0000_0000);
        $display("test encoder_mode done");

        wr(ENA, 32'h0000_0002);
        irq_chk(1'b0);
        fire(11'h00A);
        irq_chk(1'b1);
        wr(ENA, 32'h0000_0000);
        irq_chk(1'b0);
        wr(ENA, 32'h0000_0002);
        irq_chk(1'b1);
        wr(CLR, 32'hFFFF_FFFD);
        irq_chk(1'b0);
        wr(ENA, 32'h0000_0008);
        irq_chk(1'b1);
        wr(CLR, 32'hFFFF_FFF7);
        irq_chk(1'b0);
        $display("test interrupt done");

        // Trigger lands in the ack cycle, the same edge as the clear write
        fork
            wr(CLR, 32'hFFFF_FFFD);
            begin
                repeat (2) @(posedge clk_i);
                trigger_evt_i <= 1'b1;
                @(posedge clk_i);
                trigger_evt_i <= 1'b0;
            end
        join
        rd_chk(FLG, 32'h0000_0002);
        repeat (3) @(posedge clk_i);
        rd_chk(FLG, 32'h0000_0002);
        wr(CLR, 32'hFFFF_FFFD);
        rd_chk(FLG, 32'h0000_0000);
        $display("test set_priority done");
        give_verdict();
    end
endmodule
